//--- fwtc_freewheel_and_threshold_config.v
`timescale 1ns/100ps
`include "fwtc_map.vh"
// How it works
// - The pairing register picks which partner each driver engages on a set-freewheel request.
// - Pairing bit n-1 makes low-side output n the partner of high-side driver n, n 1 to 7.
// - Pairing bit 8 makes high-side driver 7 the partner of high-side driver 1.
// - Pairing bits 11 to 14 make marker outputs 0 to 3 partners of drivers 4 to 7.
// - A set force bit n activates freewheel for driver n, else the microcore request rules.
// - Force bits act with the stored pairing map even while no microcode runs.
// - Each drain-source and source threshold is held as its own 4-bit field.
// - The host writes thresholds; a microcore may write a field only with access right.
// - Codes 0, 9..C and 1..7 decode to 0 V, 0.1..0.4 V and 0.5..3.5 V; others undefined.
// - Reading threshold registers returns the thresholds in effect, not stored values.
module fwtc_freewheel_and_threshold_config
(
    input wire ref_clk,
    input wire rst_n,
    input wire hostWrite,
    input wire hostRead,
    input wire [8:0] hostAddr,
    input wire [15:0] hostWdata,
    output reg [15:0] hostRdata,
    output reg hostAddrHit,
    input wire [6:0] coreFreewheelRequest,
    input wire coreThrWrite,
    input wire coreThrSource,
    input wire [2:0] coreThrDriver,
    input wire [3:0] coreThrCode,
    input wire [6:0] coreAccessRight,
    input wire [6:0] srcOverrideEn,
    input wire [27:0] srcOverrideCode,
    output reg [6:0] lowSidePartnerOn,
    output reg topDriverSevenPartnerOn,
    output reg [3:0] auxiliaryMarkerOutputOn,
    output reg [6:0] freewheelActive,
    output reg [27:0] drainSourceThreshold,
    output reg [27:0] sourceThreshold,
    output reg [8:0] sourceLevelDriver1,
    output reg sourceCodeValidDriver1
);
    // ======================================================================
    // Storage
    // Thresholds kept as packed nibble vectors, driver 1 in the lowest nibble
    reg [15:0] pairing_reg;
    reg [15:0] force_reg;
    reg [27:0] dsThr_reg;
    reg [27:0] srcThr_reg;
    reg [27:0] dsThr_next;
    reg [27:0] srcThr_next;
    reg [27:0] srcEffective;
    reg [6:0] fwActive;
    wire [8:0] level1;
    wire valid1;
    integer i;

    // Replace one nibble of a packed 7-field threshold vector
    function [27:0] putField;
        input [27:0] vec;
        input [2:0] idx;
        input [3:0] code;
        reg [27:0] mask;
        begin
            mask = 28'h000000F << ({2'b00, idx} * 5'h04);
            putField = (vec & ~mask) | (({24'h000000, code} << ({2'b00, idx} * 5'h04)) & mask);
        end
    endfunction

    // Write strobe aimed at one register word; shared by every host write path
    function wrHit;
        input wr;
        input [8:0] addr;
        input [8:0] target;
        begin
            wrHit = wr && (addr == target);
        end
    endfunction

    // True for any word of this block; other words read as zero
    function inMap;
        input [8:0] addr;
        begin
            inMap = (addr >= `FWTC_ADDR_PAIRING) && (addr <= `FWTC_ADDR_SRC_THR_B);
        end
    endfunction

    // ======================================================================
    // Host write path; microcore writes land after host writes of same cycle
    always @*
    begin
        dsThr_next = dsThr_reg;
        srcThr_next = srcThr_reg;
        if (wrHit(hostWrite, hostAddr, `FWTC_ADDR_DS_THR_A))
            dsThr_next[15:0] = hostWdata & `FWTC_MASK_THR_A;
        if (wrHit(hostWrite, hostAddr, `FWTC_ADDR_DS_THR_B))
            dsThr_next[27:16] = hostWdata[11:0];
        if (wrHit(hostWrite, hostAddr, `FWTC_ADDR_SRC_THR_A))
            srcThr_next[15:0] = hostWdata & `FWTC_MASK_THR_A;
        if (wrHit(hostWrite, hostAddr, `FWTC_ADDR_SRC_THR_B))
            srcThr_next[27:16] = hostWdata[11:0];
        // Access right gates microcore changes; index 7 is ignored, index 6 (driver 7) is last valid
        if (coreThrWrite && coreThrDriver != 3'h7 && coreAccessRight[coreThrDriver])
        begin
            if (coreThrSource)
                srcThr_next = putField(srcThr_next, coreThrDriver, coreThrCode);
            else
                dsThr_next = putField(dsThr_next, coreThrDriver, coreThrCode);
        end
    end

    // Registers, all cleared by synchronous reset
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            pairing_reg <= `FWTC_RST_REG;
            force_reg <= `FWTC_RST_REG;
            dsThr_reg <= 28'h0000000;
            srcThr_reg <= 28'h0000000;
        end
        else
        begin
            // Reserved bits are masked on the way in, so they always read zero
            if (wrHit(hostWrite, hostAddr, `FWTC_ADDR_PAIRING))
                pairing_reg <= hostWdata & `FWTC_MASK_PAIRING;
            if (wrHit(hostWrite, hostAddr, `FWTC_ADDR_FORCE))
                force_reg <= hostWdata & `FWTC_MASK_FORCE;
            dsThr_reg <= dsThr_next;
            srcThr_reg <= srcThr_next;
        end
    end

    // ======================================================================
    // Effective source thresholds: bootstrap control may override per driver
    always @*
    begin
        srcEffective = srcThr_reg;
        for (i = 0; i < 7; i = i + 1)
            if (srcOverrideEn[i])
                srcEffective = putField(srcEffective, i[2:0], srcOverrideCode[i*4 +: 4]);
    end

    // Force bit or microcore request; force works with no microcode running
    // Limitation: the core cannot hold a driver off while its force bit is set
    always @*
    begin
        fwActive = force_reg[`FWTC_POS_FORCE_LO +: 7] | coreFreewheelRequest;
    end

    // ======================================================================
    // Registered partner outputs from pairing map and active freewheel
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            lowSidePartnerOn <= 7'h00;
            topDriverSevenPartnerOn <= 1'b0;
            auxiliaryMarkerOutputOn <= 4'h0;
            freewheelActive <= 7'h00;
        end
        else
        begin
            freewheelActive <= fwActive;
            lowSidePartnerOn <= fwActive & pairing_reg[`FWTC_POS_LS_LO +: 7];
            topDriverSevenPartnerOn <= fwActive[0] & pairing_reg[`FWTC_POS_TOP7];
            auxiliaryMarkerOutputOn <= fwActive[6:3] & pairing_reg[`FWTC_POS_MARK_LO +: 4];
        end
    end

    // Threshold outputs registered apart, so comparator trims never glitch
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            drainSourceThreshold <= 28'h0000000;
            sourceThreshold <= 28'h0000000;
            sourceLevelDriver1 <= 9'h000;
            sourceCodeValidDriver1 <= 1'b1;
        end
        else
        begin
            drainSourceThreshold <= dsThr_reg;
            sourceThreshold <= srcEffective;
            sourceLevelDriver1 <= level1;
            sourceCodeValidDriver1 <= valid1;
        end
    end

    // Decoded level of driver 1 source threshold, for the analog trim
    // Undefined codes give the bad-level marker so the trim can refuse them
    fwtc_thr_decode uDecode
    (
        .code(srcEffective[3:0]),
        .level(level1),
        .valid(valid1)
    );

    // ======================================================================
    // Read port: one cycle latency; thresholds read back as in effect
    // Address is sampled every edge, so data follows even without a read strobe
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            hostRdata <= 16'h0000;
            hostAddrHit <= 1'b0;
        end
        else
        begin
            hostAddrHit <= hostRead && inMap(hostAddr);
            case (hostAddr)
                `FWTC_ADDR_PAIRING: hostRdata <= pairing_reg;
                `FWTC_ADDR_FORCE: hostRdata <= force_reg;
                `FWTC_ADDR_DS_THR_A: hostRdata <= dsThr_reg[15:0];
                `FWTC_ADDR_DS_THR_B: hostRdata <= {4'h0, dsThr_reg[27:16]};
                `FWTC_ADDR_SRC_THR_A: hostRdata <= srcEffective[15:0];
                `FWTC_ADDR_SRC_THR_B: hostRdata <= {4'h0, srcEffective[27:16]};
                default: hostRdata <= 16'h0000;
            endcase
        end
    end
endmodule

//--- fwtc_map.vh
`ifndef FWTC_MAP_VH
`define FWTC_MAP_VH
// ==========================================================================
// Register offsets (word addresses on the register port)
`define FWTC_ADDR_PAIRING 9'h169
`define FWTC_ADDR_FORCE 9'h16A
`define FWTC_ADDR_DS_THR_A 9'h16B
`define FWTC_ADDR_DS_THR_B 9'h16C
`define FWTC_ADDR_SRC_THR_A 9'h16D
`define FWTC_ADDR_SRC_THR_B 9'h16E
// ==========================================================================
// Writable bit masks, everything else reserved
`define FWTC_MASK_PAIRING 16'h797F
`define FWTC_MASK_FORCE 16'h00FE
`define FWTC_MASK_THR_A 16'hFFFF
`define FWTC_MASK_THR_B 16'h0FFF
// ==========================================================================
// Field positions
`define FWTC_POS_LS_LO 0
`define FWTC_POS_TOP7 8
`define FWTC_POS_MARK_LO 11
`define FWTC_POS_FORCE_LO 1
`define FWTC_THR_W 4
// ==========================================================================
// Reset values
`define FWTC_RST_REG 16'h0000
// ==========================================================================
// Threshold decode results, in units of 10 mV
`define FWTC_MV10_ZERO 9'h000
`define FWTC_MV10_STEP_FINE 9'h00A
`define FWTC_MV10_STEP_COARSE 9'h032
`define FWTC_MV10_BAD 9'h1FF
`endif

//--- fwtc_thr_decode.v
`timescale 1ns/100ps
`include "fwtc_map.vh"
// ==========================================================================
// Threshold code to level, 10 mV units; undefined codes flagged
module fwtc_thr_decode
(
    input wire [3:0] code,
    output reg [8:0] level,
    output reg valid
);
    // Fine codes 9..C are 0.1 V steps, coarse 1..7 are 0.5 V steps
    always @*
    begin
        valid = 1'b1;
        level = `FWTC_MV10_ZERO;
        if (code == 4'h0)
            level = `FWTC_MV10_ZERO;
        else if (code >= 4'h9 && code <= 4'hC)
            level = `FWTC_MV10_STEP_FINE * {5'h00, code - 4'h8};
        else if (code <= 4'h7)
            level = `FWTC_MV10_STEP_COARSE * {5'h00, code};
        else
        begin
            valid = 1'b0;
            level = `FWTC_MV10_BAD;
        end
    end
endmodule

//--- fwtc_checker_assertions.sv
`timescale 1ns/100ps
// ==================================================================
// Port checks of pairing, force and readback
module fwtc_checker
(
    input wire ref_clk,
    input wire rst_n,
    input wire hostRead,
    input wire [8:0] hostAddr,
    input wire [15:0] hostRdata,
    input wire hostAddrHit,
    input wire [6:0] coreFreewheelRequest,
    input wire [6:0] freewheelActive,
    input wire [6:0] lowSidePartnerOn,
    input wire topDriverSevenPartnerOn,
    input wire [3:0] auxiliaryMarkerOutputOn
);
// One domain; partners and the active vector move on the same edge
default clocking cb @(posedge ref_clk); endclocking
default disable iff (!rst_n);
sequence mappedRead;
    hostRead && hostAddr >= 9'h169 && hostAddr <= 9'h16E;
endsequence
AST_RESET_CLEAR: assert property ($rose(rst_n) |-> !freewheelActive && !hostRdata)
    else $error("outputs not clear after reset");
AST_REQ_ACTIVE: assert property (1 |=> ($past(coreFreewheelRequest) & ~freewheelActive) == 0)
    else $error("request did not activate freewheel");
AST_LOW_PARTNER: assert property ((lowSidePartnerOn & ~freewheelActive) == 0)
    else $error("low side partner without active driver");
AST_TOP_PARTNER: assert property (topDriverSevenPartnerOn |-> freewheelActive[0])
    else $error("driver seven partner without driver one");
AST_MARK_PARTNER: assert property ((auxiliaryMarkerOutputOn & ~freewheelActive[6:3]) == 0)
    else $error("marker partner without active driver");
AST_THR_TOP_ZERO: assert property (hostAddr == 9'h16C || hostAddr == 9'h16E |=> hostRdata[15:12] == 0)
    else $error("reserved threshold nibble not zero");
AST_FORCE_RSV: assert property (hostAddr == 9'h16A |=> hostRdata[15:8] == 0 && !hostRdata[0])
    else $error("force reserved bits not zero");
AST_PAIR_RSV: assert property (hostAddr == 9'h169 |=> (hostRdata & 16'h8680) == 0)
    else $error("pairing reserved bits not zero");
AST_MAPPED_HIT: assert property (mappedRead |=> hostAddrHit)
    else $error("mapped read not acknowledged");
endmodule
bind fwtc_freewheel_and_threshold_config fwtc_checker i_chk (.ref_clk, .rst_n, .hostRead,
    .hostAddr, .hostRdata, .hostAddrHit, .coreFreewheelRequest, .freewheelActive,
    .lowSidePartnerOn, .topDriverSevenPartnerOn, .auxiliaryMarkerOutputOn);

//--- fwtc_core_model.sv
`timescale 1ns/100ps
// ==================================================================
// Microcore side: freewheel levels and threshold writes
module fwtc_core_model
(
    input wire ref_clk,
    output logic [6:0] coreFreewheelRequest = 7'h00,
    output logic [6:0] coreAccessRight = 7'h00,
    output logic coreThrWrite = 1'b0,
    output logic coreThrSource = 1'b0,
    output logic [2:0] coreThrDriver = 3'h0,
    output logic [3:0] coreThrCode = 4'h0
);
// Levels move on the falling edge only
task automatic setLevels(input logic [6:0] req, input logic [6:0] right);
    @(negedge ref_clk);
    coreFreewheelRequest = req;
    coreAccessRight = right;
endtask
// Pulse spans one sampling edge; code is scrambled after so stale data cannot pass
task automatic thrWrite(input logic src, input logic [2:0] drv, input logic [3:0] code);
    @(negedge ref_clk);
    {coreThrWrite, coreThrSource, coreThrDriver, coreThrCode} = {1'b1, src, drv, code};
    @(negedge ref_clk);
    {coreThrWrite, coreThrCode} = {1'b0, ~code};
endtask
endmodule

//--- tb.sv
`timescale 1ns/100ps
`include "fwtc_map.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module tb;
// ==================================================================
// Stimulus, reference model and checks
logic ref_clk = 0, rst_n = 0, hostWrite = 0, hostRead = 0, src;
logic [8:0] hostAddr = 9'h169, a, lvl;
logic [15:0] hostWdata = 0, rm [0:5];
logic [6:0] srcOverrideEn = 0;
logic [27:0] srcOverrideCode = 0;
logic [31:0] r;
logic [2:0] drv;
logic [3:0] code;
int i, seed, fail_count = 0, num_checks = 0;
wire [15:0] hostRdata;
wire [6:0] cReq, cRight, lowSidePartnerOn, freewheelActive;
wire [27:0] drainSourceThreshold, sourceThreshold;
wire [8:0] sourceLevelDriver1;
wire [3:0] cCode, auxiliaryMarkerOutputOn;
wire [2:0] cDrv;
wire hostAddrHit, cWr, cSrc, topDriverSevenPartnerOn, sourceCodeValidDriver1;
logic [15:0] mk [0:5] = '{`FWTC_MASK_PAIRING, `FWTC_MASK_FORCE, `FWTC_MASK_THR_A,
    `FWTC_MASK_THR_B, `FWTC_MASK_THR_A, `FWTC_MASK_THR_B};
fwtc_core_model i_fwtc_core_model (.ref_clk(ref_clk), .coreFreewheelRequest(cReq),
    .coreAccessRight(cRight), .coreThrWrite(cWr), .coreThrSource(cSrc),
    .coreThrDriver(cDrv), .coreThrCode(cCode));
fwtc_freewheel_and_threshold_config i_fwtc_freewheel_and_threshold_config (.ref_clk, .rst_n,
    .hostWrite, .hostRead, .hostAddr, .hostWdata, .hostRdata, .hostAddrHit,
    .coreFreewheelRequest(cReq), .coreThrWrite(cWr), .coreThrSource(cSrc),
    .coreThrDriver(cDrv), .coreThrCode(cCode), .coreAccessRight(cRight), .srcOverrideEn,
    .srcOverrideCode, .lowSidePartnerOn, .topDriverSevenPartnerOn, .auxiliaryMarkerOutputOn,
    .freewheelActive, .drainSourceThreshold, .sourceThreshold, .sourceLevelDriver1,
    .sourceCodeValidDriver1);
always #5 ref_clk = ~ref_clk;
// Source thresholds as seen after the bootstrap override
function automatic logic [27:0] effSrc();
    logic [27:0] s;
    s = {rm[5][11:0], rm[4]};
    for (int k = 0; k < 7; k++)
        if (srcOverrideEn[k]) s[4 * k +: 4] = srcOverrideCode[4 * k +: 4];
    return s;
endfunction
function automatic logic [15:0] expRd(input logic [8:0] ad);
    if (ad < 9'h169 || ad > 9'h16E) return 16'h0000;
    if (ad == 9'h16D) return 16'(effSrc());
    if (ad == 9'h16E) return 16'(effSrc() >> 16);
    return rm[ad - 9'h169];
endfunction
task automatic hwr(input logic [8:0] ad, input logic [15:0] d);
    @(negedge ref_clk);
    {hostWrite, hostAddr, hostWdata} = {1'b1, ad, d};
    @(negedge ref_clk);
    hostWrite = 0;
    if (ad >= 9'h169 && ad <= 9'h16E) rm[ad - 9'h169] = d & mk[ad - 9'h169];
endtask
// Settle three cycles, then one read and a sweep of every output but the driver 1 decoded level and valid flag
task automatic check(input logic [8:0] ad);
    logic [6:0] act;
    act = rm[1][7:1] | cReq;
    repeat (3) @(negedge ref_clk);
    {hostRead, hostAddr} = {1'b1, ad};
    @(negedge ref_clk);
    hostRead = 0;
    `CHK(hostRdata, expRd(ad))
    `CHK(hostAddrHit, (ad >= 9'h169 && ad <= 9'h16E))
    `CHK(freewheelActive, act)
    `CHK(lowSidePartnerOn, act & rm[0][6:0])
    `CHK(topDriverSevenPartnerOn, act[0] & rm[0][8])
    `CHK(auxiliaryMarkerOutputOn, act[6:3] & rm[0][14:11])
    `CHK(drainSourceThreshold, {rm[3][11:0], rm[2]})
    `CHK(sourceThreshold, effSrc())
endtask
task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
        $display("Testbench passed");
    else
        $display("Testbench failed");
    $finish;
endtask
// Watchdog, far beyond the expected run of some seven hundred cycles
initial
begin
    #100000;
    fail_count++;
    conclude;
end
initial
begin
    seed = 95027;
    for (i = 0; i < 6; i++) rm[i] = 0;
    repeat (8) @(negedge ref_clk);
    rst_n = 1;
    for (a = 9'h168; a <= 9'h16F; a++) check(a);
    hwr(9'h169, 16'hFFFF);
    hwr(9'h16A, 16'hFFFF);
    check(9'h16A);
    $display("test reset and force done");
    for (i = 0; i < 16; i++)
    begin
        hwr(9'h16D, i);
        check(9'h16D);
        lvl = (i == 0) ? 0 : (i < 8) ? i * 50 : (i - 8) * 10;
        `CHK(sourceCodeValidDriver1, (i < 8 || (i > 8 && i < 13)))
        `CHK(sourceLevelDriver1, (i < 8 || (i > 8 && i < 13)) ? lvl : `FWTC_MV10_BAD)
    end
    $display("test decode done");
    for (i = 0; i < 60; i++)
    begin
        r = $random(seed);
        i_fwtc_core_model.setLevels(r[6:0], r[13:7]);
        srcOverrideEn = (r[14] ? r[21:15] : 0);
        srcOverrideCode = $random(seed);
        hwr(9'h168 + r[24:22], $random(seed));
        {src, drv, code} = $random(seed);
        i_fwtc_core_model.thrWrite(src, drv, code);
        if (cRight[drv] && drv < 7) rm[(src ? 4 : 2) + (drv > 3)][4 * drv[1:0] +: 4] = code;
        check(9'h168 + r[27:25]);
    end
    $display("test random traffic done");
    i_fwtc_core_model.setLevels(0, 0);
    srcOverrideEn = 0;
    rst_n = 0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1;
    for (i = 0; i < 6; i++) rm[i] = 0;
    check(9'h16E);
    $display("test mid-run reset done");
    conclude;
end
endmodule
